// File: core/mpfs_defs.vh
// Register offsets, field positions and reset values of the pin function select block
`ifndef MPFS_DEFS_VH
`define MPFS_DEFS_VH
`define MPFS_PWM_SEL_IDX 8'h0a
`define MPFS_SYNC_SER_IDX 8'h0b
`define MPFS_PWM_SEL_ADDR 12'h028
`define MPFS_SYNC_SER_ADDR 12'h02c
`define MPFS_CTRL_ADDR 12'h030
`define MPFS_STATUS_ADDR 12'h034
`define MPFS_DDR_A_ADDR 12'h040
`define MPFS_DDR_B_ADDR 12'h044
`define MPFS_DDR_C_ADDR 12'h048
`define MPFS_DDR_D_ADDR 12'h04c
`define MPFS_DAT_A_ADDR 12'h050
`define MPFS_DAT_B_ADDR 12'h054
`define MPFS_DAT_C_ADDR 12'h058
`define MPFS_DAT_D_ADDR 12'h05c
`define MPFS_SDA_BIT 0
`define MPFS_SCL_BIT 1
`define MPFS_VSYNC_BIT 6
`define MPFS_HSYNC_BIT 7
`define MPFS_CTRL_IRQ_LEVEL_BIT 0
`define MPFS_CTRL_HPOL_BIT 1
`define MPFS_CTRL_VPOL_BIT 2
`define MPFS_REG_RESET 8'h00
`endif

// File: core/mpfs_pin_select.v
// Pin function select for the four general ports with APB register access
//
// Implementation choice: the APB interface to the registers.
`include "mpfs_defs.vh"
`default_nettype none

module mpfs_pin_select (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] first_port_lines_in,
  output wire [7:0] first_port_lines_out,
  output wire [7:0] first_port_lines_oe,
  input wire [5:0] second_port_lines_in,
  output wire [5:0] second_port_lines_out,
  output wire [5:0] second_port_lines_oe,
  input wire [7:0] third_port_lines_in,
  output wire [7:0] third_port_lines_out,
  output wire [7:0] third_port_lines_oe,
  input wire [1:0] fourth_port_lines_in,
  output wire [1:0] fourth_port_lines_out,
  output wire [1:0] fourth_port_lines_oe,
  input wire [15:0] pwm_channels,
  output wire [7:0] dedicated_pwm_outputs,
  input wire horiz_sync_out,
  input wire vert_sync_out,
  input wire sda_out_low,
  input wire scl_out_low,
  output wire sda_in,
  output wire scl_in,
  input wire hsync_pin,
  input wire vsync_pin,
  output wire hsync_pos,
  output wire vsync_pos,
  input wire irq_n_pin,
  input wire irq_ack,
  output wire irq_req
);

  reg [7:0] pwm_pin_select_ff;
  reg [7:0] sync_and_serial_pin_select_ff;
  reg [2:0] ctrl_ff;
  reg [7:0] ddr_a_ff;
  reg [7:0] dat_a_ff;
  reg [7:0] ddr_c_ff;
  reg [7:0] dat_c_ff;
  reg [5:0] ddr_b_ff;
  reg [5:0] dat_b_ff;
  reg [1:0] ddr_d_ff;
  reg [1:0] dat_d_ff;
  reg irq_prev_ff;
  reg irq_pend_ff;
  reg [31:0] nxt_prdata;
  reg hit;
  wire wr_en;
  wire rd_en;
  wire irq_fall;
  wire [7:0] c_alt_en;
  wire [7:0] c_alt_val;
  wire horiz_sync_out_select;
  wire vert_sync_out_select;
  wire pwm_ch15_select;
  wire pwm_ch14_select;
  wire ser_sda_sel;
  wire ser_scl_sel;
  wire sel_pwm;
  wire sel_sync_ser;
  wire sel_ctrl;
  wire sel_ddr_a;
  wire sel_ddr_b;
  wire sel_ddr_c;
  wire sel_ddr_d;
  wire sel_dat_a;
  wire sel_dat_b;
  wire sel_dat_c;
  wire sel_dat_d;
  wire [7:0] rd_b_port;
  wire [7:0] rd_d_port;

  // Pin read back: input level where direction is input, latch otherwise
  function [7:0] rd_port;
    input [7:0] ddr;
    input [7:0] dat;
    input [7:0] pin;
    begin
      rd_port = (ddr & dat) | (~ddr & pin);
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;

  // Address decode, one select per writable register (status has none)
  assign sel_pwm = (paddr == `MPFS_PWM_SEL_ADDR);
  assign sel_sync_ser = (paddr == `MPFS_SYNC_SER_ADDR);
  assign sel_ctrl = (paddr == `MPFS_CTRL_ADDR);
  assign sel_ddr_a = (paddr == `MPFS_DDR_A_ADDR);
  assign sel_ddr_b = (paddr == `MPFS_DDR_B_ADDR);
  assign sel_ddr_c = (paddr == `MPFS_DDR_C_ADDR);
  assign sel_ddr_d = (paddr == `MPFS_DDR_D_ADDR);
  assign sel_dat_a = (paddr == `MPFS_DAT_A_ADDR);
  assign sel_dat_b = (paddr == `MPFS_DAT_B_ADDR);
  assign sel_dat_c = (paddr == `MPFS_DAT_C_ADDR);
  assign sel_dat_d = (paddr == `MPFS_DAT_D_ADDR);

  // Narrow ports padded to the function width, then cut back
  assign rd_b_port = rd_port({2'b00, ddr_b_ff}, {2'b00, dat_b_ff}, {2'b00, second_port_lines_in});
  assign rd_d_port = rd_port({6'h00, ddr_d_ff}, {6'h00, dat_d_ff}, {6'h00, fourth_port_lines_in});

  // Configuration registers: every shared pin starts as a plain port pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_pin_select_ff <= `MPFS_REG_RESET;
    end else if (wr_en && sel_pwm) begin
      pwm_pin_select_ff <= pwdata[7:0];
    end
  end

  // Unused middle bits are kept at zero so they read back as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_and_serial_pin_select_ff <= `MPFS_REG_RESET;
    end else if (wr_en && sel_sync_ser) begin
      sync_and_serial_pin_select_ff <= pwdata[7:0] & 8'hc3;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 3'h0;
    end else if (wr_en && sel_ctrl) begin
      ctrl_ff <= pwdata[2:0];
    end
  end

  // Direction registers: cleared by reset so no pin drives until software asks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddr_a_ff <= 8'h00;
    end else if (wr_en && sel_ddr_a) begin
      ddr_a_ff <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddr_b_ff <= 6'h00;
    end else if (wr_en && sel_ddr_b) begin
      ddr_b_ff <= pwdata[5:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddr_c_ff <= 8'h00;
    end else if (wr_en && sel_ddr_c) begin
      ddr_c_ff <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddr_d_ff <= 2'h0;
    end else if (wr_en && sel_ddr_d) begin
      ddr_d_ff <= pwdata[1:0];
    end
  end

  // Output latches; reset value is harmless since direction is input
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_a_ff <= 8'h00;
    end else if (wr_en && sel_dat_a) begin
      dat_a_ff <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_b_ff <= 6'h00;
    end else if (wr_en && sel_dat_b) begin
      dat_b_ff <= pwdata[5:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_c_ff <= 8'h00;
    end else if (wr_en && sel_dat_c) begin
      dat_c_ff <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_d_ff <= 2'h0;
    end else if (wr_en && sel_dat_d) begin
      dat_d_ff <= pwdata[1:0];
    end
  end

  always @* begin
    hit = 1'b1;
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `MPFS_PWM_SEL_ADDR: nxt_prdata[7:0] = pwm_pin_select_ff;
      `MPFS_SYNC_SER_ADDR: nxt_prdata[7:0] = sync_and_serial_pin_select_ff;
      `MPFS_CTRL_ADDR: nxt_prdata[2:0] = ctrl_ff;
      `MPFS_STATUS_ADDR: nxt_prdata[3:0] = {irq_n_pin, irq_pend_ff, hsync_pos, vsync_pos};
      `MPFS_DDR_A_ADDR: nxt_prdata[7:0] = ddr_a_ff;
      `MPFS_DDR_B_ADDR: nxt_prdata[5:0] = ddr_b_ff;
      `MPFS_DDR_C_ADDR: nxt_prdata[7:0] = ddr_c_ff;
      `MPFS_DDR_D_ADDR: nxt_prdata[1:0] = ddr_d_ff;
      `MPFS_DAT_A_ADDR: nxt_prdata[7:0] = rd_port(ddr_a_ff, dat_a_ff, first_port_lines_in);
      `MPFS_DAT_B_ADDR: nxt_prdata[5:0] = rd_b_port[5:0];
      `MPFS_DAT_C_ADDR: nxt_prdata[7:0] = rd_port(ddr_c_ff, dat_c_ff, third_port_lines_in);
      `MPFS_DAT_D_ADDR: nxt_prdata[1:0] = rd_d_port[1:0];
      default: hit = 1'b0;
    endcase
  end

  // Registered read data, captured in the setup cycle; unmapped reads return zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata <= hit ? nxt_prdata : 32'h0000_0000;
    end
  end

  // First and second ports have no alternate function
  assign first_port_lines_out = dat_a_ff;
  assign first_port_lines_oe = ddr_a_ff;
  assign second_port_lines_out = dat_b_ff;
  assign second_port_lines_oe = ddr_b_ff;

  assign dedicated_pwm_outputs = pwm_channels[7:0];

  assign horiz_sync_out_select = sync_and_serial_pin_select_ff[`MPFS_HSYNC_BIT];
  assign vert_sync_out_select = sync_and_serial_pin_select_ff[`MPFS_VSYNC_BIT];
  assign pwm_ch15_select = pwm_pin_select_ff[7];
  assign pwm_ch14_select = pwm_pin_select_ff[6];

  assign c_alt_en[5:0] = pwm_pin_select_ff[5:0];
  assign c_alt_val[5:0] = pwm_channels[13:8];
  assign c_alt_en[6] = vert_sync_out_select | pwm_ch14_select;
  assign c_alt_val[6] = vert_sync_out_select ? vert_sync_out : pwm_channels[14];
  assign c_alt_en[7] = horiz_sync_out_select | pwm_ch15_select;
  assign c_alt_val[7] = horiz_sync_out_select ? horiz_sync_out : pwm_channels[15];

  assign third_port_lines_out = (c_alt_en & c_alt_val) | (~c_alt_en & dat_c_ff);
  assign third_port_lines_oe = c_alt_en | ddr_c_ff;

  assign ser_sda_sel = sync_and_serial_pin_select_ff[`MPFS_SDA_BIT];
  assign ser_scl_sel = sync_and_serial_pin_select_ff[`MPFS_SCL_BIT];

  // Open drain on the serial bus: only ever drive low, direction bits ignored
  assign fourth_port_lines_out[0] = ser_sda_sel ? 1'b0 : dat_d_ff[0];
  assign fourth_port_lines_oe[0] = ser_sda_sel ? sda_out_low : ddr_d_ff[0];
  assign fourth_port_lines_out[1] = ser_scl_sel ? 1'b0 : dat_d_ff[1];
  assign fourth_port_lines_oe[1] = ser_scl_sel ? scl_out_low : ddr_d_ff[1];
  assign sda_in = ser_sda_sel ? fourth_port_lines_in[0] : 1'b1;
  assign scl_in = ser_scl_sel ? fourth_port_lines_in[1] : 1'b1;

  // Polarity normalisation: software states which level is active
  assign hsync_pos = hsync_pin ^ ctrl_ff[`MPFS_CTRL_HPOL_BIT];
  assign vsync_pos = vsync_pin ^ ctrl_ff[`MPFS_CTRL_VPOL_BIT];

  assign irq_fall = irq_prev_ff & ~irq_n_pin;

  // Previous level idles high, so a pin held low when leaving reset counts as a falling edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_prev_ff <= 1'b1;
    end else begin
      irq_prev_ff <= irq_n_pin;
    end
  end

  // Edge latch; set wins over acknowledge so a new edge is never lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_ff <= 1'b0;
    end else begin
      irq_pend_ff <= irq_fall | (irq_pend_ff & ~irq_ack);
    end
  end

  assign irq_req = irq_pend_ff | (ctrl_ff[`MPFS_CTRL_IRQ_LEVEL_BIT] & ~irq_n_pin);

endmodule
`default_nettype wire

// File: tb/mpfs_pin_select_monitor.sv
// Assertions on the pin function select ports
`default_nettype none
module mpfs_pin_monitor (
  input wire pclk, input wire presetn, input wire psel, input wire penable, input wire pwrite,
  input wire [11:0] paddr, input wire [31:0] pwdata, input wire [15:0] pwm_channels,
  input wire [7:0] first_port_lines_oe, input wire [5:0] second_port_lines_oe,
  input wire [7:0] dedicated_pwm_outputs, input wire [7:0] third_port_lines_out,
  input wire [7:0] third_port_lines_oe, input wire [1:0] fourth_port_lines_out,
  input wire [1:0] fourth_port_lines_oe, input wire horiz_sync_out, input wire sda_out_low,
  input wire hsync_pin, input wire hsync_pos
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] c1_ff, c2_ff, ct_ff;
  logic [1:0] dd_ff;
  // Sync select masks the shared top pins
  wire [7:0] pwm_on = c1_ff & ~{c2_ff[7:6], 6'h00};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) begin
      c1_ff <= 8'h00;
      c2_ff <= 8'h00;
      ct_ff <= 8'h00;
      dd_ff <= 2'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == 12'h028) c1_ff <= pwdata[7:0];
      if (paddr == 12'h02c) c2_ff <= pwdata[7:0];
      if (paddr == 12'h030) ct_ff <= pwdata[7:0];
      if (paddr == 12'h04c) dd_ff <= pwdata[1:0];
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_oe_at_reset: assert property ($rose(presetn) |->
    {first_port_lines_oe, second_port_lines_oe, third_port_lines_oe, fourth_port_lines_oe} == 24'h0)
    else $error("pin driven after reset");
  a_pwm_fixed: assert property (dedicated_pwm_outputs == pwm_channels[7:0])
    else $error("fixed pwm wrong");
  a_pwm_shared: assert property ((((third_port_lines_out ^ pwm_channels[15:8]) | ~third_port_lines_oe) & pwm_on) == 8'h00)
    else $error("shared pwm wrong");
  a_hsync_wins: assert property (c2_ff[7] |-> third_port_lines_out[7] == horiz_sync_out && third_port_lines_oe[7])
    else $error("sync out wrong");
  a_serial_od: assert property (c2_ff[0] |-> !fourth_port_lines_out[0] && fourth_port_lines_oe[0] == sda_out_low)
    else $error("serial pin wrong");
  a_hsync_pol: assert property (hsync_pos == (hsync_pin ^ ct_ff[1]))
    else $error("sync polarity wrong");
  a_port_d_plain: assert property (c2_ff[1:0] == 2'h0 |-> fourth_port_lines_oe == dd_ff)
    else $error("port d direction wrong");
  a_sel_follows: assert property ($rose(c1_ff[0]) |-> third_port_lines_oe[0])
    else $error("pwm select late");
endmodule
bind mpfs_pin_select mpfs_pin_monitor u_mon (.*);
`default_nettype wire

// File: tb/mpfs_far_model.sv
// Far side sources: PWM, sync processor, serial engine, host sync
`default_nettype none
module mpfs_far_model (
  input wire logic pclk,
  input wire logic presetn,
  output logic [15:0] pwm_channels,
  output logic horiz_sync_out,
  output logic vert_sync_out,
  output logic sda_out_low,
  output logic scl_out_low,
  output logic hsync_pin,
  output logic vsync_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cnt_ff;
  // Sources move every cycle so a stale route shows
  always @(posedge pclk or negedge presetn)
    if (!presetn) cnt_ff <= 16'h0000;
    else cnt_ff <= cnt_ff + 16'h9e37;
  assign pwm_channels = cnt_ff;
  assign {horiz_sync_out, vert_sync_out, sda_out_low, scl_out_low} = cnt_ff[15:12];
  assign {hsync_pin, vsync_pin} = cnt_ff[11:10];
endmodule
`default_nettype wire

// File: tb/mpfs_pin_select_test.sv
// Self-checking bench for the pin function select block
`default_nettype none
module mpfs_pin_select_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq_n_pin = 1, irq_ack = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] pwm_channels;
  logic [7:0] first_port_lines_out, first_port_lines_oe, third_port_lines_out, third_port_lines_oe;
  logic [7:0] dedicated_pwm_outputs;
  logic [5:0] second_port_lines_out, second_port_lines_oe;
  logic [1:0] fourth_port_lines_out, fourth_port_lines_oe;
  logic pready, pslverr, horiz_sync_out, vert_sync_out, sda_out_low, scl_out_low, sda_in, scl_in;
  logic hsync_pin, vsync_pin, hsync_pos, vsync_pos, irq_req;
  int err_count = 0, check_count = 0;
  // Pull-ups on the open-drain pair
  wire [1:0] fourth_port_lines_in = ~fourth_port_lines_oe | fourth_port_lines_out;
  mpfs_pin_select DUT (.*, .first_port_lines_in(8'h5a), .second_port_lines_in(6'h15), .third_port_lines_in(8'ha5));
  mpfs_far_model far (.*);
  always #2.5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs();
    apb(0, 12'h028, 0);
    chk(rd, 0);
    chk({first_port_lines_oe, second_port_lines_oe, third_port_lines_oe}, 0);
    apb(1, 12'h02c, 32'hffffffff);
    apb(0, 12'h02c, 0);
    chk(rd, 32'hc3);
    apb(0, 12'h100, 0);
    chk(rd, 0);
  endtask
  task automatic t_ports();
    apb(1, 12'h040, 32'hf0);
    apb(1, 12'h050, 32'h33);
    apb(1, 12'h044, 32'h3c);
    apb(1, 12'h054, 32'h0f);
    @(negedge pclk);
    chk({first_port_lines_oe, first_port_lines_out}, 16'hf033);
    chk({second_port_lines_oe, second_port_lines_out}, 12'hf0f);
    apb(0, 12'h050, 0);
    chk(rd, 32'h3a);
    apb(0, 12'h054, 0);
    chk(rd, 32'h0d);
  endtask
  task automatic t_shared();
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h028, {i[0], i[0], 6'h3f});
      apb(1, 12'h02c, {i[1], i[1], 6'h00});
      @(negedge pclk);
      chk(third_port_lines_oe, {i ? 2'h3 : 2'h0, 6'h3f});
      if (i > 1) chk(third_port_lines_out[7:6], {horiz_sync_out, vert_sync_out});
      else chk(third_port_lines_out[5:0], pwm_channels[13:8]);
    end
  endtask
  task automatic t_serial();
    apb(1, 12'h04c, 3);
    apb(1, 12'h05c, 3);
    @(negedge pclk);
    chk({fourth_port_lines_oe, fourth_port_lines_out}, 4'hf);
    chk({scl_in, sda_in}, 2'h3);
    apb(1, 12'h02c, 3);
    @(negedge pclk);
    chk({fourth_port_lines_oe, fourth_port_lines_out}, {scl_out_low, sda_out_low, 2'h0});
    chk({scl_in, sda_in}, {~scl_out_low, ~sda_out_low});
  endtask
  task automatic t_sync_irq();
    for (int p = 0; p < 2; p++) begin
      apb(1, 12'h030, {p[0], p[0], 1'b0});
      @(negedge pclk);
      chk({hsync_pos, vsync_pos}, {hsync_pin, vsync_pin} ^ {p[0], p[0]});
    end
    @(posedge pclk);
    irq_n_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(irq_req, 1);
    @(posedge pclk);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    @(negedge pclk);
    chk(irq_req, 0);
    apb(1, 12'h030, 1);
    @(negedge pclk);
    chk(irq_req, 1);
    @(posedge pclk);
    irq_n_pin <= 1'b1;
    apb(1, 12'h030, 0);
    @(negedge pclk);
    chk(irq_req, 0);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ports();
    t_shared();
    t_serial();
    t_sync_irq();
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h02c, 0);
    chk(rd, 0);
    test_done();
  end
endmodule
`default_nettype wire
